// >>> logic/wpc_playback_ctrl.sv
// Register access over Avalon-MM and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "wpc_map.svh"

module wpc_playback_ctrl
  import wpc_pkg::*;
#(
  parameter int ITEMS         = 16,                 // sequence item slots
  parameter int WAVES         = 8,                  // waveform descriptors
  parameter int SAMPLES       = 256,                // stored sample words
  parameter int START_LAT     = `WPC_START_LAT_SMP, // sample ticks to first sample
  parameter int RAMP_FAST_CYC = `WPC_RAMP_FAST_MS * (`WPC_CLK_HZ / 1000),
  parameter int RAMP_SLOW_CYC = `WPC_RAMP_SLOW_MS * (`WPC_CLK_HZ / 1000)
) (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output      logic [31:0] avs_readdata,
  output      logic        avs_waitrequest,
  input  wire logic        trig_in,
  input  wire logic        estop_in,
  output      wpc_dac_s    dac_out
);

  // refuse sizes the fields cannot hold
  if (ITEMS < 1 || ITEMS > 16 || WAVES < 1 || WAVES > 8 || SAMPLES < 2 || SAMPLES > 256 ||
      START_LAT < 1 || START_LAT > 256 || RAMP_FAST_CYC < 1 || RAMP_SLOW_CYC < 1 ||
      RAMP_FAST_CYC > 131072 || RAMP_SLOW_CYC > 131072) begin : g_param_check
    $error("wpc_playback_ctrl: unsupported parameter values");
  end

  // byte-lane merge of write data over current contents
  function automatic logic [31:0] be_merge(logic [31:0] old_v, logic [31:0] new_v, logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // address falls inside a table of n words
  function automatic logic in_rgn(logic [11:0] a, logic [11:0] base, int n);
    return (int'(a) >= int'(base)) && (int'(a) < int'(base) + 4 * n);
  endfunction : in_rgn

  // one step of a ramp toward zero
  function automatic logic [15:0] ramp_step(logic [15:0] v, logic [15:0] s);
    logic [15:0] mag;
    mag = v[15] ? 16'(-v) : v;
    if (mag > s) begin
      return v[15] ? 16'(v + s) : 16'(v - s);
    end
    return 16'h0000;
  endfunction : ramp_step

  // software-visible settings
  wpc_mode_e   mode_reg;      // generation_behavior_select
  logic        adv_reg;       // advance_immediately
  logic        en_reg;        // channel enable
  logic        fast_reg;      // fast emergency ramp
  logic [16:0] burst_cnt_reg; // burst_repeat_count
  logic [15:0] holdoff_reg;   // trigger holdoff, clocks
  logic [4:0]  seq_len_reg;   // items in use, 0 = single waveform
  logic [15:0] rate_div_reg;  // clocks per sample minus one
  logic [15:0] nslope_reg;    // normal_ramp_slope
  logic [15:0] eslope_reg;    // emergency_ramp_slope

  // tables
  wpc_item_s   item_mem [ITEMS];
  wpc_wave_s   wave_mem [WAVES];
  logic [15:0] smp_mem  [SAMPLES];

  // bus slave
  logic        ack_reg;       // answer phase of an access
  logic [31:0] rdata_reg;     // read data, held after answer
  logic [31:0] rd_mux;        // readback of addressed word
  logic [31:0] wd_m;          // merged write data
  logic        bus_wr;        // write taken this edge
  logic        cmd_wr;        // command word written
  logic        cmd_abort;     // abort pulse
  logic        cmd_release;   // shutdown_release_command pulse
  logic        cmd_trig;      // software trigger pulse

  // pin synchronisers: index 0 trigger, 1 shutdown
  logic [1:0]  pin_raw;
  logic [2:0]  pin_sync_reg [2];
  logic [1:0]  pin_lvl_reg;   // agreed level
  logic [1:0]  pin_rise;      // agreed rising edge

  // playback
  wpc_state_e  state_reg;
  logic [3:0]  item_reg;      // current item
  logic [7:0]  offs_reg;      // offset within waveform
  logic [15:0] rep_reg;       // plays completed of this item
  logic [16:0] burst_reg;     // bursts completed
  logic [7:0]  lat_reg;       // latency countdown
  logic [15:0] div_reg;       // sample divider
  logic [15:0] hold_reg;      // holdoff countdown
  logic        pend_reg;      // trigger waiting for waveform end
  logic        emerg_reg;     // ramp is an emergency ramp
  logic [16:0] rcnt_reg;      // emergency ramp timer
  logic [15:0] smp_reg;       // sample on the output
  logic        vld_reg;       // sample strobe

  // derived controls
  logic        tick;
  logic        trig_evt;
  logic        trig_ok;
  logic        adv_req;
  logic        advance_immediately_cut;
  logic        consume;
  logic        estop_lvl;
  logic        go_emerg;
  logic        go_stop;
  logic        use_seq;
  wpc_item_s   cur_item;
  wpc_wave_s   cur_wave;
  logic [15:0] eff_reps;
  logic        wave_end;
  logic        reps_done;
  logic        last_item;
  logic [3:0]  nxt_item;
  logic [16:0] burst_tgt;
  logic        burst_done;
  logic        burst_start;
  logic        ramp_done;
  logic [7:0]  smp_addr;

  // waitrequest drops one cycle after a request
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign avs_readdata    = rdata_reg;
  assign bus_wr          = avs_write & ack_reg;
  assign wd_m            = be_merge(rd_mux, avs_writedata, avs_byteenable);
  assign cmd_wr          = bus_wr && (avs_address == `WPC_OFS_CMD);
  assign cmd_abort       = cmd_wr & wd_m[`WPC_CMD_ABORT_BIT];
  assign cmd_release     = cmd_wr & wd_m[`WPC_CMD_REL_BIT];
  assign cmd_trig        = cmd_wr & wd_m[`WPC_CMD_TRIG_BIT];

  // answer phase and read capture
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
      if (avs_read && !ack_reg) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // readback mux, unmapped reads zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (in_rgn(avs_address, `WPC_BASE_ITEM, ITEMS)) begin
      rd_mux = {13'h0000, item_mem[avs_address[5:2]]};
    end else if (in_rgn(avs_address, `WPC_BASE_WAVE, WAVES)) begin
      rd_mux = {16'h0000, wave_mem[avs_address[4:2]]};
    end else if (in_rgn(avs_address, `WPC_BASE_SMP, SAMPLES)) begin
      rd_mux = {16'h0000, smp_mem[avs_address[9:2]]};
    end else begin
      case (avs_address)
        `WPC_OFS_CTRL:     rd_mux = {27'h0000000, fast_reg, en_reg, adv_reg, mode_reg};
        `WPC_OFS_BURST:    rd_mux = {15'h0000, burst_cnt_reg};
        `WPC_OFS_HOLDOFF:  rd_mux = {16'h0000, holdoff_reg};
        `WPC_OFS_SEQ_LEN:  rd_mux = {27'h0000000, seq_len_reg};
        `WPC_OFS_RATE_DIV: rd_mux = {16'h0000, rate_div_reg};
        `WPC_OFS_NSLOPE:   rd_mux = {16'h0000, nslope_reg};
        `WPC_OFS_ESLOPE:   rd_mux = {16'h0000, eslope_reg};
        `WPC_OFS_STATUS:   rd_mux = {22'h000000, estop_lvl, emerg_reg, state_reg == ST_OFF, item_reg, state_reg};
        `WPC_OFS_SAMPLE:   rd_mux = {16'h0000, smp_reg};
        default:           rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // setting registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mode_reg      <= MODE_CONT;
      adv_reg       <= 1'b0;
      en_reg        <= 1'b0;
      fast_reg      <= 1'b0;
      burst_cnt_reg <= `WPC_RST_BURST;
      holdoff_reg   <= `WPC_RST_HOLDOFF;
      seq_len_reg   <= `WPC_RST_SEQ_LEN;
      rate_div_reg  <= `WPC_RST_RATE_DIV;
      nslope_reg    <= `WPC_RST_NSLOPE;
      eslope_reg    <= `WPC_RST_ESLOPE;
    end else if (cmd_abort) begin
      // abort also withdraws the enable
      en_reg <= 1'b0;
    end else if (bus_wr) begin
      case (avs_address)
        `WPC_OFS_CTRL: begin
          // only the three modes are taken
          if (wd_m[`WPC_CTRL_MODE_LSB +: 2] != 2'h3) begin
            mode_reg <= wpc_mode_e'(wd_m[`WPC_CTRL_MODE_LSB +: 2]);
          end
          adv_reg  <= wd_m[`WPC_CTRL_ADV_BIT];
          en_reg   <= wd_m[`WPC_CTRL_EN_BIT];
          fast_reg <= wd_m[`WPC_CTRL_FAST_BIT];
        end
        `WPC_OFS_BURST:    burst_cnt_reg <= wd_m[16:0];
        `WPC_OFS_HOLDOFF:  holdoff_reg   <= wd_m[15:0];
        `WPC_OFS_SEQ_LEN:  seq_len_reg   <= (wd_m[4:0] > 5'(ITEMS)) ? 5'(ITEMS) : wd_m[4:0];
        `WPC_OFS_RATE_DIV: rate_div_reg  <= wd_m[15:0];
        `WPC_OFS_NSLOPE:   nslope_reg    <= wd_m[15:0];
        `WPC_OFS_ESLOPE:   eslope_reg    <= wd_m[15:0];
        default: ;
      endcase
    end
  end

  // table writes, no reset
  always_ff @(posedge sys_clk) begin
    if (bus_wr && in_rgn(avs_address, `WPC_BASE_ITEM, ITEMS)) begin
      item_mem[avs_address[5:2]] <= wd_m[18:0];
    end
    if (bus_wr && in_rgn(avs_address, `WPC_BASE_WAVE, WAVES)) begin
      wave_mem[avs_address[4:2]] <= wd_m[15:0];
    end
    if (bus_wr && in_rgn(avs_address, `WPC_BASE_SMP, SAMPLES)) begin
      smp_mem[avs_address[9:2]] <= wd_m[15:0];
    end
  end

  // three-stage pin synchronisers
  assign pin_raw = {estop_in, trig_in};
  for (genvar g = 0; g < 2; g++) begin : g_sync
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        pin_sync_reg[g] <= 3'h0;
        pin_lvl_reg[g]  <= 1'b0;
      end else begin
        pin_sync_reg[g] <= {pin_sync_reg[g][1:0], pin_raw[g]};
        if (pin_sync_reg[g][1] == pin_sync_reg[g][2]) begin
          pin_lvl_reg[g] <= pin_sync_reg[g][2];
        end
      end
    end
    assign pin_rise[g] = (pin_sync_reg[g][1] == pin_sync_reg[g][2]) & pin_sync_reg[g][2] & ~pin_lvl_reg[g];
  end

  assign estop_lvl = pin_lvl_reg[1];
  assign trig_evt  = pin_rise[0] | cmd_trig;

  // sample-rate divider
  assign tick = (div_reg == 16'h0000);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= tick ? rate_div_reg : 16'(div_reg - 16'h0001);
    end
  end

  // current item and waveform
  assign use_seq   = (seq_len_reg != 5'h00);
  // item selects waveform and repeat count
  assign cur_item  = item_mem[item_reg];
  assign cur_wave  = use_seq ? wave_mem[cur_item.wave] : wave_mem[0];
  // zero repeats means endless outside burst/continuous
  assign eff_reps  = !use_seq ? 16'h0001 :
                     (mode_reg != MODE_SEQ && cur_item.repeat_n == 16'h0000) ? 16'h0001 : cur_item.repeat_n;
  assign wave_end  = (offs_reg == cur_wave.last_ofs);
  assign reps_done = (eff_reps != 16'h0000) && (16'(rep_reg + 16'h0001) >= eff_reps);
  assign last_item = !use_seq || ({1'b0, item_reg} == 5'(seq_len_reg - 5'h01));
  assign nxt_item  = last_item ? 4'h0 : 4'(item_reg + 4'h1);
  assign smp_addr  = 8'(cur_wave.start + offs_reg);
  assign burst_tgt = (burst_cnt_reg == 17'h00000) ? 17'h00001 : burst_cnt_reg;
  assign burst_done = (17'(burst_reg + 17'h00001) >= burst_tgt);

  // trigger qualification
  // burst triggers ignored during holdoff
  assign trig_ok     = (mode_reg != MODE_BURST) || (hold_reg == 16'h0000);
  assign adv_req     = pend_reg | (trig_evt & trig_ok);
  // advance setting picks cut or wait
  assign advance_immediately_cut   = (state_reg == ST_PLAY) && (mode_reg == MODE_SEQ) && adv_reg && trig_evt;
  assign consume     = (state_reg == ST_HOLD) ||
                       ((state_reg == ST_PLAY) && tick && wave_end && (mode_reg == MODE_SEQ));
  assign burst_start = ((state_reg == ST_ARMED) && trig_evt) ||
                       ((state_reg == ST_HOLD) && (mode_reg == MODE_BURST) && adv_req);
  assign go_emerg    = estop_lvl && (state_reg != ST_OFF) && !((state_reg == ST_RAMP) && emerg_reg);
  assign go_stop     = (cmd_abort || !en_reg) &&
                       (state_reg inside {ST_ARMED, ST_LATENCY, ST_PLAY, ST_HOLD});
  assign ramp_done   = emerg_reg ? (rcnt_reg == 17'h00000) : (smp_reg == 16'h0000);

  // pending trigger, the event in a consuming cycle is used there
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pend_reg <= 1'b0;
    end else if (!(state_reg inside {ST_PLAY, ST_HOLD}) || consume) begin
      pend_reg <= 1'b0;
    end else if (trig_evt && trig_ok && !advance_immediately_cut && mode_reg != MODE_CONT) begin
      pend_reg <= 1'b1;
    end
  end

  // holdoff countdown from each burst start
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hold_reg <= 16'h0000;
    end else if (burst_start) begin
      hold_reg <= holdoff_reg;
    end else if (hold_reg != 16'h0000) begin
      hold_reg <= 16'(hold_reg - 16'h0001);
    end
  end

  // playback sequencer
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      item_reg  <= 4'h0;
      offs_reg  <= 8'h00;
      rep_reg   <= 16'h0000;
      burst_reg <= 17'h00000;
      lat_reg   <= 8'h00;
    end else if (go_emerg) begin
      state_reg <= ST_RAMP;
    end else if (go_stop) begin
      state_reg <= ST_RAMP;
    end else begin
      case (state_reg)
        ST_IDLE: if (en_reg) begin
          state_reg <= ST_ARMED;
        end
        ST_ARMED: if (trig_evt) begin
          state_reg <= ST_LATENCY;
          lat_reg   <= 8'(START_LAT - 1);
          item_reg  <= 4'h0;
          offs_reg  <= 8'h00;
          rep_reg   <= 16'h0000;
          burst_reg <= 17'h00000;
        end
        ST_LATENCY: if (tick) begin
          if (lat_reg == 8'h00) begin
            state_reg <= ST_PLAY;
          end else begin
            lat_reg <= 8'(lat_reg - 8'h01);
          end
        end
        ST_PLAY: if (advance_immediately_cut) begin
          item_reg <= nxt_item;
          offs_reg <= 8'h00;
          rep_reg  <= 16'h0000;
        end else if (tick) begin
          if (!wave_end) begin
            offs_reg <= 8'(offs_reg + 8'h01);
          end else begin
            offs_reg <= 8'h00;
            if (mode_reg == MODE_SEQ && adv_req) begin
              item_reg <= nxt_item;
              rep_reg  <= 16'h0000;
            end else if (!reps_done) begin
              rep_reg <= 16'(rep_reg + 16'h0001);
            end else if (mode_reg == MODE_SEQ) begin
              state_reg <= ST_HOLD;
            end else if (!last_item) begin
              item_reg <= nxt_item;
              rep_reg  <= 16'h0000;
            end else if (mode_reg == MODE_CONT) begin
              item_reg <= 4'h0;
              rep_reg  <= 16'h0000;
            end else if (!burst_done) begin
              item_reg  <= 4'h0;
              rep_reg   <= 16'h0000;
              burst_reg <= 17'(burst_reg + 17'h00001);
            end else begin
              state_reg <= ST_HOLD;
            end
          end
        end
        ST_HOLD: if (adv_req && mode_reg != MODE_CONT) begin
          state_reg <= ST_PLAY;
          offs_reg  <= 8'h00;
          rep_reg   <= 16'h0000;
          if (mode_reg == MODE_SEQ) begin
            // trigger steps on, wraps after last
            item_reg <= nxt_item;
          end else begin
            item_reg  <= 4'h0;
            burst_reg <= 17'h00000;
          end
        end
        ST_RAMP: if (ramp_done) begin
          state_reg <= emerg_reg ? ST_OFF : ST_IDLE;
        end
        ST_OFF: if (cmd_release && !estop_lvl) begin
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // emergency ramp kind and timer
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      emerg_reg <= 1'b0;
      rcnt_reg  <= 17'h00000;
    end else if (go_emerg) begin
      emerg_reg <= 1'b1;
      rcnt_reg  <= fast_reg ? 17'(RAMP_FAST_CYC - 1) : 17'(RAMP_SLOW_CYC - 1);
    end else if (state_reg == ST_IDLE) begin
      emerg_reg <= 1'b0;
    end else if (rcnt_reg != 17'h00000) begin
      rcnt_reg <= 17'(rcnt_reg - 17'h00001);
    end
  end

  // output sample
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      smp_reg <= 16'h0000;
      vld_reg <= 1'b0;
    end else begin
      vld_reg <= tick && (state_reg inside {ST_PLAY, ST_HOLD, ST_RAMP});
      if (state_reg == ST_PLAY && tick && !advance_immediately_cut && !go_emerg && !go_stop) begin
        smp_reg <= smp_mem[smp_addr];
      end else if (state_reg == ST_RAMP) begin
        if (emerg_reg && rcnt_reg == 17'h00000) begin
          smp_reg <= 16'h0000;
        end else begin
          smp_reg <= ramp_step(smp_reg, emerg_reg ? eslope_reg : nslope_reg);
        end
      end else if (state_reg inside {ST_IDLE, ST_ARMED, ST_LATENCY, ST_OFF}) begin
        smp_reg <= 16'h0000;
      end
      // hold keeps the last sample
    end
  end

  assign dac_out.sample = smp_reg;
  assign dac_out.valid  = vld_reg;

endmodule : wpc_playback_ctrl

// >>> logic/wpc_map.svh
`ifndef WPC_MAP_SVH
`define WPC_MAP_SVH

// register byte offsets
`define WPC_OFS_CTRL      12'h000
`define WPC_OFS_BURST     12'h004
`define WPC_OFS_HOLDOFF   12'h008
`define WPC_OFS_SEQ_LEN   12'h00C
`define WPC_OFS_RATE_DIV  12'h010
`define WPC_OFS_NSLOPE    12'h014
`define WPC_OFS_ESLOPE    12'h018
`define WPC_OFS_CMD       12'h01C
`define WPC_OFS_STATUS    12'h020
`define WPC_OFS_SAMPLE    12'h024
`define WPC_BASE_ITEM     12'h100
`define WPC_BASE_WAVE     12'h200
`define WPC_BASE_SMP      12'h400

// field positions
`define WPC_CTRL_MODE_LSB 0
`define WPC_CTRL_ADV_BIT  2
`define WPC_CTRL_EN_BIT   3
`define WPC_CTRL_FAST_BIT 4
`define WPC_CMD_ABORT_BIT 0
`define WPC_CMD_REL_BIT   1
`define WPC_CMD_TRIG_BIT  2

// reset values
`define WPC_RST_BURST     17'h00001
`define WPC_RST_HOLDOFF   16'h0000
`define WPC_RST_SEQ_LEN   5'h00
`define WPC_RST_RATE_DIV  16'h0000
`define WPC_RST_NSLOPE    16'h0040
`define WPC_RST_ESLOPE    16'h0100

// timing
`define WPC_CLK_HZ        10000000
`define WPC_RAMP_FAST_MS  5
`define WPC_RAMP_SLOW_MS  10
`define WPC_START_LAT_SMP 56

`endif

// >>> logic/wpc_pkg.sv
package wpc_pkg;

  // playback control states
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_ARMED   = 3'h1,
    ST_LATENCY = 3'h2,
    ST_PLAY    = 3'h3,
    ST_HOLD    = 3'h4,
    ST_RAMP    = 3'h5,
    ST_OFF     = 3'h6
  } wpc_state_e;

  // generation behaviour select
  typedef enum logic [1:0] {
    MODE_CONT  = 2'h0,
    MODE_BURST = 2'h1,
    MODE_SEQ   = 2'h2
  } wpc_mode_e;

  // one sequence item: waveform reference and repeat count
  typedef struct packed {
    logic [2:0]  wave;
    logic [15:0] repeat_n;
  } wpc_item_s;

  // waveform descriptor: first sample and last offset
  typedef struct packed {
    logic [7:0] start;
    logic [7:0] last_ofs;
  } wpc_wave_s;

  // sample toward the dac
  typedef struct packed {
    logic [15:0] sample;
    logic        valid;
  } wpc_dac_s;

endpackage : wpc_pkg

// >>> testbench/wpc_playback_ctrl_properties.sv
`timescale 1ns/1ps
module wpc_props
  import wpc_pkg::*;
#(
  parameter int RAMP_SLOW_CYC = 40  // slow emergency ramp clocks
) (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic [11:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        trig_in,
  input wire logic        estop_in,
  input wire wpc_dac_s    dac_out
);
  int   e_cnt;  // clocks with estop held
  logic fired;  // any trigger so far
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // estop hold counter, saturating
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) e_cnt <= 0;
    else if (!estop_in) e_cnt <= 0;
    else if (e_cnt < 999) e_cnt <= e_cnt + 1;
  end
  // pin trigger or any command word write seen
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) fired <= 1'b0;
    else if (trig_in || (avs_write && avs_address == 12'h01C)) fired <= 1'b1;
  end
  property p_wait_one; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait longer than one cycle");
  property p_wait_first; $rose(avs_read || avs_write) |-> avs_waitrequest; endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait in first cycle");
  property p_wait_idle; !(avs_read || avs_write) |-> !avs_waitrequest; endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("wait without request");
  property p_rd_stand; !avs_read |=> $stable(avs_readdata); endproperty
  a_rd_stand: assert property (p_rd_stand) else $error("read data moved");
  property p_unmapped; avs_read && !avs_waitrequest && avs_address == 12'hFFC |-> avs_readdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_quiet; !fired |-> !dac_out.valid; endproperty
  a_quiet: assert property (p_quiet) else $error("sample before trigger");
  property p_off_quiet; e_cnt > RAMP_SLOW_CYC + 8 |-> !dac_out.valid; endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("output after shutdown");
  property p_off_zero; e_cnt > RAMP_SLOW_CYC + 8 |-> dac_out.sample == 16'h0; endproperty
  a_off_zero: assert property (p_off_zero) else $error("level after shutdown");
endmodule : wpc_props
bind wpc_playback_ctrl wpc_props #(.RAMP_SLOW_CYC(RAMP_SLOW_CYC)) u_props (.sys_clk, .resetn, .avs_address,
  .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .trig_in, .estop_in, .dac_out);

// >>> testbench/wpc_far_end.sv
`timescale 1ns/1ps
module wpc_far_end
  import wpc_pkg::*;
(
  input  wire logic     sys_clk,
  input  wire logic     resetn,
  input  wire logic     fire,
  input  wire wpc_dac_s dac_out,
  output logic          trig_in,
  output int            n_valid
);
  logic [2:0] left;  // pulse clocks left
  // trigger pulse of four clocks, low otherwise
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) left <= 3'h0;
    else if (fire) left <= 3'h4;
    else if (left != 3'h0) left <= left - 3'h1;
  end
  assign trig_in = (left != 3'h0);
  // dac sink counts taken samples
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) n_valid <= 0;
    else if (dac_out.valid) n_valid <= n_valid + 1;
  end
endmodule : wpc_far_end

// >>> testbench/tb.sv
`timescale 1ns/1ps
`include "wpc_map.svh"
module tb;
  import wpc_pkg::*;
  logic        sys_clk, resetn, avs_read, avs_write, estop_in, fire, trig_in, avs_waitrequest;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [15:0] smp [8];  // stored samples
  wpc_dac_s    dac_out;
  int          n_valid, err_total, compares;
  wpc_playback_ctrl #(.START_LAT(2), .RAMP_FAST_CYC(20), .RAMP_SLOW_CYC(40)) dut (.sys_clk, .resetn,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
    .avs_waitrequest, .trig_in, .estop_in, .dac_out);
  wpc_far_end far (.sys_clk, .resetn, .fire, .dac_out, .trig_in, .n_valid);
  // 100 ns clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one avalon access, held until waitrequest low
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    avs_read <= ~w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  // poll status until state s
  task automatic wait_st(input logic [2:0] s);
    repeat (300) begin
      bus(1'b0, `WPC_OFS_STATUS, 32'h0);
      if (q[2:0] === s) break;
    end
    chk(q[2:0], s);
  endtask : wait_st
  // pin trigger, then let it land
  task automatic pulse;
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask : pulse
  // abort and wait for idle
  task automatic stop;
    bus(1'b1, `WPC_OFS_CMD, 32'h1);
    wait_st(3'h0);
  endtask : stop
  function automatic logic [15:0] last_of(input int w);
    return smp[w * 4 + 3];
  endfunction : last_of
  task automatic complete_run;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  // watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    complete_run();
  end
  initial begin
    {resetn, avs_read, avs_write, estop_in, fire, avs_address, avs_writedata} = '0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    void'($urandom(32'h894e));
    bus(1'b0, `WPC_OFS_NSLOPE, 32'h0);
    chk(q, 32'h40);
    bus(1'b0, 12'hFFC, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, `WPC_OFS_BURST, 32'h10000);
    bus(1'b0, `WPC_OFS_BURST, 32'h0);
    chk(q, 32'h10000);
    foreach (smp[i]) begin
      smp[i] = 16'($urandom);
      bus(1'b1, 12'(`WPC_BASE_SMP + 4 * i), {16'h0, smp[i]});
    end
    bus(1'b1, `WPC_BASE_WAVE, 32'h0300);
    bus(1'b1, `WPC_BASE_WAVE + 12'h4, 32'h0304);
    bus(1'b1, `WPC_BASE_ITEM, 32'h1);
    bus(1'b1, `WPC_BASE_ITEM + 12'h4, 32'h10002);
    // continuous: silent until trigger, then runs on
    bus(1'b1, `WPC_OFS_CTRL, 32'h08);
    repeat (20) @(posedge sys_clk);
    chk(n_valid, 0);
    pulse();
    repeat (40) @(posedge sys_clk);
    chk(n_valid > 20, 1'b1);
    bus(1'b0, `WPC_OFS_STATUS, 32'h0);
    chk(q[2:0], 3'h3);
    stop();
    bus(1'b0, `WPC_OFS_SAMPLE, 32'h0);
    chk(q[15:0], 16'h0);
    // burst of two, then hold last sample
    bus(1'b1, `WPC_OFS_BURST, 32'h2);
    bus(1'b1, `WPC_OFS_CTRL, 32'h09);
    pulse();
    wait_st(3'h4);
    bus(1'b0, `WPC_OFS_SAMPLE, 32'h0);
    chk(q[15:0], last_of(0));
    stop();
    // sequenced, synchronous advance
    bus(1'b1, `WPC_OFS_SEQ_LEN, 32'h2);
    bus(1'b1, `WPC_OFS_CTRL, 32'h0A);
    pulse();
    wait_st(3'h4);
    chk(q[6:3], 4'h0);
    pulse();
    wait_st(3'h4);
    bus(1'b0, `WPC_OFS_SAMPLE, 32'h0);
    chk(q[15:0], last_of(1));
    stop();
    // endless item cut short by trigger
    bus(1'b1, `WPC_BASE_ITEM, 32'h0);
    bus(1'b1, `WPC_OFS_CTRL, 32'h0E);
    pulse();
    repeat (40) @(posedge sys_clk);
    bus(1'b0, `WPC_OFS_STATUS, 32'h0);
    chk({q[6:3], q[2:0]}, 7'h03);
    pulse();
    bus(1'b0, `WPC_OFS_STATUS, 32'h0);
    chk(q[6:3], 4'h1);
    // fast emergency shutdown, early release ignored
    bus(1'b1, `WPC_OFS_CTRL, 32'h1E);
    estop_in <= 1'b1;
    repeat (10) @(posedge sys_clk);
    bus(1'b1, `WPC_OFS_CMD, 32'h2);
    bus(1'b0, `WPC_OFS_STATUS, 32'h0);
    chk(q[2:0], 3'h5);
    repeat (40) @(posedge sys_clk);
    bus(1'b0, `WPC_OFS_STATUS, 32'h0);
    chk(q[2:0], 3'h6);
    estop_in <= 1'b0;
    repeat (5) @(posedge sys_clk);
    bus(1'b0, `WPC_OFS_STATUS, 32'h0);
    chk(q[2:0], 3'h6);
    // release only after ramp done
    bus(1'b1, `WPC_OFS_CMD, 32'h2);
    bus(1'b0, `WPC_OFS_STATUS, 32'h0);
    chk(q[2:0], 3'h1);
    complete_run();
  end
endmodule : tb
